// File: hw/swk_trim_pkg.sv
// Constants for the selective wake trim and clock recovery register group
package swk_trim_pkg;
    localparam logic [6:0] ADDR_OSC_FINE_TRIM   = 7'h38;
    localparam logic [6:0] ADDR_WAKE_OPTIONS    = 7'h39;
    localparam logic [6:0] ADDR_CAL_HIGH        = 7'h3A;
    localparam logic [6:0] ADDR_CAL_LOW         = 7'h3B;
    localparam logic [6:0] ADDR_RECOVERY_ONE    = 7'h3C;
    localparam logic [6:0] ADDR_RECOVERY_TWO    = 7'h3D;
    localparam logic [1:0] TRIM_UNLOCKED        = 2'h3;
    localparam int         FINE_LSB             = 0;
    localparam int         FINE_MSB             = 4;
    localparam int         OPT_WAKE_SEL_BIT     = 7;
    localparam int         OPT_COARSE_MSB       = 4;
    localparam int         RC1_FILT_LSB         = 2;
    localparam int         RC1_FILT_MSB         = 3;
    localparam int         RC1_ON_BIT           = 0;
    localparam logic [7:0] CAL_RESET            = 8'h00;
    localparam logic [1:0] FILT_RESET           = 2'h1;
    localparam logic       ON_RESET             = 1'b0;
    localparam logic [1:0] CLK_RESET            = 2'h0;
    localparam logic       WAKE_SEL_RESET       = 1'b0;
    localparam logic [1:0] FILT_8               = 2'h0;
    localparam logic [1:0] FILT_16              = 2'h1;
    localparam logic [1:0] FILT_32              = 2'h2;
    localparam logic [1:0] FILT_ADAPT           = 2'h3;
    localparam logic [5:0] TC_8                 = 6'h08;
    localparam logic [5:0] TC_16                = 6'h10;
    localparam logic [5:0] TC_32                = 6'h20;
    localparam logic [3:0] GAP_SHORT_MIN        = 4'h2;
    localparam logic [3:0] GAP_SHORT_MAX        = 4'h3;
    localparam logic [3:0] GAP_MID_MAX          = 4'h8;
    localparam logic [3:0] GAP_LONG_MAX         = 4'hA;
    localparam logic [6:0] MHZ_80               = 7'h50;
    localparam logic [6:0] MHZ_40               = 7'h28;
    localparam logic [6:0] MHZ_20               = 7'h14;
    localparam logic [6:0] MHZ_10               = 7'h0A;
endpackage : swk_trim_pkg

// File: hw/recovery_calc_if.sv
// Signals between the register bank and the recovery calculation unit
`timescale 1ns/1ps
interface recovery_calc_if;
    logic [1:0] filter_code;
    logic [3:0] edge_gap_bits;
    logic [7:0] bit_time;
    logic [7:0] upper_limit;
    logic [7:0] lower_limit;
    logic [5:0] time_constant;
    logic [7:0] bit_time_clamped;

    modport bank (output filter_code, edge_gap_bits, bit_time, upper_limit, lower_limit,
                  input  time_constant, bit_time_clamped);
    modport calc (input  filter_code, edge_gap_bits, bit_time, upper_limit, lower_limit,
                  output time_constant, bit_time_clamped);
endinterface : recovery_calc_if

// File: hw/recovery_calc.sv
// Filter time constant selection and bit-time clamping for clock recovery
`timescale 1ns/1ps
module recovery_calc
    import swk_trim_pkg::*;
(
    recovery_calc_if.calc calc_bus   // Codes in, constant and clamped time out
);
    always_comb begin
        case (calc_bus.filter_code)
            FILT_8:  calc_bus.time_constant = TC_8;
            FILT_16: calc_bus.time_constant = TC_16;
            FILT_32: calc_bus.time_constant = TC_32;
            default: begin
                // Gaps outside 2..10 bits fall back to the middle constant
                if (calc_bus.edge_gap_bits >= GAP_SHORT_MIN &&
                    calc_bus.edge_gap_bits <= GAP_SHORT_MAX) begin
                    calc_bus.time_constant = TC_32;
                end else if (calc_bus.edge_gap_bits > GAP_MID_MAX &&
                             calc_bus.edge_gap_bits <= GAP_LONG_MAX) begin
                    calc_bus.time_constant = TC_8;
                end else begin
                    calc_bus.time_constant = TC_16;
                end
            end
        endcase
    end

    always_comb begin
        if (calc_bus.bit_time > calc_bus.upper_limit) begin
            calc_bus.bit_time_clamped = calc_bus.upper_limit;
        end else if (calc_bus.bit_time < calc_bus.lower_limit) begin
            calc_bus.bit_time_clamped = calc_bus.lower_limit;
        end else begin
            calc_bus.bit_time_clamped = calc_bus.bit_time;
        end
    end
endmodule : recovery_calc

// File: hw/swk_osc_trim_cdr_regs.sv
// Selective wake oscillator trim and clock recovery register bank
// Function
// - Trim writes ignored unless unlock equals 11
// - Low five trim bits: monotonic fine trim; code writes and drives all eight bits
// - Options bits 4:0 hold coarse trim
// - Options bit 7 picks wake receiver, locked
// - Reserved bits always read zero
// - Calibration bytes read-only, reset to zero
// - Filter codes 00/01/10 give 8/16/32
// - Filter code 11 adapts to edge spacing
// - Control one bit 0 enables recovery
// - Clock select gives 80/40/20/10 MHz
// - Control one resets to 0000 0100
// - Bit time clamped between limit registers
`timescale 1ns/1ps
module swk_osc_trim_cdr_regs
    import swk_trim_pkg::*;
#(
    parameter logic [7:0] FINE_TRIM_RESET   = 8'h00,  // Factory value not fixed here
    parameter logic [4:0] COARSE_TRIM_RESET = 5'h00   // Factory value not fixed here
) (
    input  wire logic        i_ref_clk,                   // 20 MHz clock
    input  wire logic        i_rst_n,                     // Power-on reset
    input  wire logic        i_soft_reset,                // Soft reset request
    input  wire logic        i_cmd_valid,                 // Register command strobe
    input  wire logic        i_cmd_write,                 // 1 write, 0 read
    input  wire logic [6:0]  i_cmd_addr,                  // Register address
    input  wire logic [7:0]  i_cmd_wdata,                 // Write data byte
    output logic      [7:0]  o_cmd_rdata,                 // Read data byte
    output logic             o_cmd_rvalid,                // Read data valid pulse
    input  wire logic [1:0]  i_trim_unlock,               // Trim unlock field
    input  wire logic [7:0]  i_calibration_high_byte,     // Calibration high source
    input  wire logic [7:0]  i_calibration_low_byte,      // Calibration low source
    input  wire logic [3:0]  i_edge_gap_bits,             // Falling edge spacing, bits
    input  wire logic [7:0]  i_bit_time,                  // Measured bit time
    input  wire logic [7:0]  i_recovery_upper_limit,      // Bit time upper limit
    input  wire logic [7:0]  i_recovery_lower_limit,      // Bit time lower limit
    output logic      [12:0] o_oscillator_tune_code,      // Full trim code
    output logic             o_wake_receiver_choice,      // 1 low-power receiver
    output logic             o_recovery_on,               // Recovery enable
    output logic      [1:0]  o_recovery_filter_constant,  // Filter code
    output logic      [5:0]  o_time_constant,             // Effective filter constant
    output logic      [1:0]  o_recovery_clock_choice,     // Clock select code
    output logic      [6:0]  o_recovery_clock_mhz,        // Recovery clock in MHz
    output logic      [7:0]  o_bit_time_clamped           // Limited bit time
);
    typedef struct packed {
        logic [7:0] fine_trim;
        logic [4:0] coarse_trim;
        logic       wake_sel;
        logic [7:0] cal_high;
        logic [7:0] cal_low;
        logic [1:0] filt;
        logic       on;
        logic [1:0] clk_sel;
        logic [7:0] rdata;
        logic       rvalid;
        logic [5:0] tc;
        logic [6:0] mhz;
        logic [7:0] bt;
    } state_t;

    state_t state;
    state_t next_state;
    logic   wr;
    logic   unlocked;

    recovery_calc_if calc_bus ();

    recovery_calc u_calc (
        .calc_bus (calc_bus.calc)
    );

    assign calc_bus.filter_code   = state.filt;
    assign calc_bus.edge_gap_bits = i_edge_gap_bits;
    assign calc_bus.bit_time      = i_bit_time;
    assign calc_bus.upper_limit   = i_recovery_upper_limit;
    assign calc_bus.lower_limit   = i_recovery_lower_limit;

    assign wr       = i_cmd_valid && i_cmd_write;
    assign unlocked = (i_trim_unlock == TRIM_UNLOCKED);

    always_comb begin
        next_state        = state;
        next_state.rvalid = 1'b0;
        // Calibration bytes follow their source; writes cannot reach them
        next_state.cal_high = i_calibration_high_byte;
        next_state.cal_low  = i_calibration_low_byte;
        next_state.tc       = calc_bus.time_constant;
        next_state.bt       = calc_bus.bit_time_clamped;
        case (state.clk_sel)
            2'h0:    next_state.mhz = MHZ_80;
            2'h1:    next_state.mhz = MHZ_40;
            2'h2:    next_state.mhz = MHZ_20;
            default: next_state.mhz = MHZ_10;
        endcase
        if (wr) begin
            case (i_cmd_addr)
                ADDR_OSC_FINE_TRIM: begin
                    if (unlocked) begin
                        next_state.fine_trim = i_cmd_wdata;
                    end
                end
                ADDR_WAKE_OPTIONS: begin
                    if (unlocked) begin
                        next_state.coarse_trim = i_cmd_wdata[OPT_COARSE_MSB:0];
                        next_state.wake_sel    = i_cmd_wdata[OPT_WAKE_SEL_BIT];
                    end
                end
                ADDR_RECOVERY_ONE: begin
                    next_state.filt = i_cmd_wdata[RC1_FILT_MSB:RC1_FILT_LSB];
                    next_state.on   = i_cmd_wdata[RC1_ON_BIT];
                end
                ADDR_RECOVERY_TWO: begin
                    next_state.clk_sel = i_cmd_wdata[1:0];
                end
                default: begin
                    next_state.rdata = state.rdata;   // Unmapped or read-only: no effect
                end
            endcase
        end else if (i_cmd_valid) begin
            next_state.rvalid = 1'b1;
            // Reserved positions return zero
            case (i_cmd_addr)
                ADDR_OSC_FINE_TRIM: next_state.rdata = state.fine_trim;
                ADDR_WAKE_OPTIONS:  next_state.rdata = {state.wake_sel, 2'h0,
                                                        state.coarse_trim};
                ADDR_CAL_HIGH:      next_state.rdata = state.cal_high;
                ADDR_CAL_LOW:       next_state.rdata = state.cal_low;
                ADDR_RECOVERY_ONE:  next_state.rdata = {4'h0, state.filt, 1'b0,
                                                        state.on};
                ADDR_RECOVERY_TWO:  next_state.rdata = {6'h00, state.clk_sel};
                default:            next_state.rdata = 8'h00;
            endcase
        end
        if (i_soft_reset) begin
            // Soft reset clears like power-on; trim keeps its factory default
            next_state.fine_trim   = FINE_TRIM_RESET;
            next_state.coarse_trim = COARSE_TRIM_RESET;
            next_state.wake_sel    = WAKE_SEL_RESET;
            next_state.cal_high    = CAL_RESET;
            next_state.cal_low     = CAL_RESET;
            next_state.filt        = FILT_RESET;
            next_state.on          = ON_RESET;
            next_state.clk_sel     = CLK_RESET;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state             <= '0;
            state.fine_trim   <= FINE_TRIM_RESET;
            state.coarse_trim <= COARSE_TRIM_RESET;
            state.wake_sel    <= WAKE_SEL_RESET;
            state.cal_high    <= CAL_RESET;
            state.cal_low     <= CAL_RESET;
            state.filt        <= FILT_RESET;
            state.on          <= ON_RESET;
            state.clk_sel     <= CLK_RESET;
            state.tc          <= TC_16;
            state.mhz         <= MHZ_80;
        end else begin
            state <= next_state;
        end
    end

    assign o_cmd_rdata                = state.rdata;
    assign o_cmd_rvalid               = state.rvalid;
    assign o_oscillator_tune_code     = {state.coarse_trim, state.fine_trim};
    assign o_wake_receiver_choice     = state.wake_sel;
    assign o_recovery_on              = state.on;
    assign o_recovery_filter_constant = state.filt;
    assign o_time_constant            = state.tc;
    assign o_recovery_clock_choice    = state.clk_sel;
    assign o_recovery_clock_mhz       = state.mhz;
    assign o_bit_time_clamped         = state.bt;
endmodule : swk_osc_trim_cdr_regs

// File: tb/swk_regs_monitor.sv
// Port checker for the trim and recovery register bank
`timescale 1ns/1ps
module swk_regs_monitor
    import swk_trim_pkg::*;
(
    input wire logic        i_ref_clk, i_rst_n, i_soft_reset, i_cmd_valid, i_cmd_write,
    input wire logic [6:0]  i_cmd_addr,
    input wire logic [7:0]  i_cmd_wdata,
    input wire logic [1:0]  i_trim_unlock,
    input wire logic [3:0]  i_edge_gap_bits,
    input wire logic [7:0]  i_bit_time, i_recovery_upper_limit, i_recovery_lower_limit,
    input wire logic [12:0] o_oscillator_tune_code,
    input wire logic        o_wake_receiver_choice, o_recovery_on,
    input wire logic [1:0]  o_recovery_filter_constant, o_recovery_clock_choice,
    input wire logic [5:0]  o_time_constant,
    input wire logic [6:0]  o_recovery_clock_mhz,
    input wire logic [7:0]  o_bit_time_clamped
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    sequence wr_s(a);
        i_cmd_valid && i_cmd_write && !i_soft_reset && i_cmd_addr == a;
    endsequence
    sequence open_wr_s(a);
        wr_s(a) ##0 i_trim_unlock == TRIM_UNLOCKED;
    endsequence
    locked_trim_hold_a: assert property (i_cmd_valid && i_cmd_write && !i_soft_reset
        && i_trim_unlock != TRIM_UNLOCKED |=> $stable(o_oscillator_tune_code)
        && $stable(o_wake_receiver_choice)) else $error("locked trim changed");
    fine_write_a: assert property (open_wr_s(ADDR_OSC_FINE_TRIM)
        |=> o_oscillator_tune_code[7:0] == $past(i_cmd_wdata)) else $error("fine trim bad");
    coarse_write_a: assert property (open_wr_s(ADDR_WAKE_OPTIONS) |=>
        {o_wake_receiver_choice, 2'h0, o_oscillator_tune_code[12:8]}
        == ($past(i_cmd_wdata) & 8'h9F)) else $error("options write bad");
    control_write_a: assert property (wr_s(ADDR_RECOVERY_ONE) |=>
        {4'h0, o_recovery_filter_constant, 1'b0, o_recovery_on}
        == ($past(i_cmd_wdata) & 8'h0D)) else $error("control one write bad");
    fixed_filter_a: assert property (o_recovery_filter_constant != FILT_ADAPT
        |=> o_time_constant == (TC_8 << $past(o_recovery_filter_constant)))
        else $error("filter constant bad");
    adapt_filter_a: assert property (o_recovery_filter_constant == FILT_ADAPT
        && i_edge_gap_bits inside {[GAP_SHORT_MIN:GAP_LONG_MAX]} |=> o_time_constant ==
        ($past(i_edge_gap_bits) <= GAP_SHORT_MAX ? TC_32 :
        $past(i_edge_gap_bits) <= GAP_MID_MAX ? TC_16 : TC_8)) else $error("adapt bad");
    clock_mhz_a: assert property (1'b1 |=> o_recovery_clock_mhz
        == (MHZ_80 >> $past(o_recovery_clock_choice))) else $error("clock rate bad");
    clamp_high_a: assert property (i_bit_time > i_recovery_upper_limit
        |=> o_bit_time_clamped == $past(i_recovery_upper_limit)) else $error("upper clamp bad");
    clamp_low_a: assert property (i_bit_time < i_recovery_lower_limit
        && i_recovery_lower_limit <= i_recovery_upper_limit
        |=> o_bit_time_clamped == $past(i_recovery_lower_limit)) else $error("lower clamp bad");
endmodule : swk_regs_monitor

// File: tb/host_model.sv
// Host side model issuing single byte register commands
`timescale 1ns/1ps
module host_model (
    input  wire logic       i_ref_clk, // Bank clock
    input  wire logic [7:0] i_rdata,   // Read byte
    input  wire logic       i_rvalid,  // Read answer pulse
    output logic            o_valid,   // Command strobe
    output logic            o_write,   // Write flag
    output logic      [6:0] o_addr,    // Register address
    output logic      [7:0] o_wdata    // Write byte
);
    initial {o_valid, o_write, o_addr, o_wdata} = '0;
    // Fine trim left as given by caller; recovery absorbs drift
    task automatic cmd(input logic w, input logic [6:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge i_ref_clk) #2;
        {o_valid, o_write, o_addr, o_wdata} = {1'b1, w, a, d};
        @(posedge i_ref_clk) #2;
        o_valid = 1'b0;
        // Released lines show the inverse so stale values cannot pass
        o_addr = ~a;
        o_wdata = ~d;
        q = (!w && i_rvalid === 1'b1) ? i_rdata : 8'hXX;
    endtask : cmd
    // Coarse bits taken from the caller's argument and written with the select; not read back first
    task automatic wake_select(input logic sel, input logic [4:0] coarse);
        logic [7:0] q;
        cmd(1'b1, 7'h39, {sel, 2'h0, coarse}, q);
    endtask : wake_select
endmodule : host_model

// File: tb/testbench.sv
// Self-checking bench for the trim and recovery register bank
`timescale 1ns/1ps
module testbench;
    import swk_trim_pkg::*;
    logic        i_ref_clk = 1'b0, i_rst_n = 1'b0, i_soft_reset = 1'b0;
    logic        i_cmd_valid, i_cmd_write, o_cmd_rvalid, o_wake_receiver_choice, o_recovery_on;
    logic [6:0]  i_cmd_addr, o_recovery_clock_mhz;
    logic [7:0]  i_cmd_wdata, o_cmd_rdata, o_bit_time_clamped;
    logic [1:0]  i_trim_unlock = 2'h0, o_recovery_filter_constant, o_recovery_clock_choice;
    logic [7:0]  i_calibration_high_byte = 8'h5A, i_calibration_low_byte = 8'hC3;
    logic [3:0]  i_edge_gap_bits = 4'h5;
    logic [7:0]  i_bit_time = 8'hA0, i_recovery_upper_limit = 8'hA8;
    logic [7:0]  i_recovery_lower_limit = 8'h98;
    logic [12:0] o_oscillator_tune_code;
    logic [5:0]  o_time_constant;
    int          err_count = 0, num_checks = 0, cycles = 0;
    swk_osc_trim_cdr_regs DUT (.i_ref_clk, .i_rst_n, .i_soft_reset, .i_cmd_valid, .i_cmd_write,
        .i_cmd_addr, .i_cmd_wdata, .o_cmd_rdata, .o_cmd_rvalid, .i_trim_unlock,
        .i_calibration_high_byte, .i_calibration_low_byte, .i_edge_gap_bits, .i_bit_time,
        .i_recovery_upper_limit, .i_recovery_lower_limit, .o_oscillator_tune_code,
        .o_wake_receiver_choice, .o_recovery_on, .o_recovery_filter_constant, .o_time_constant,
        .o_recovery_clock_choice, .o_recovery_clock_mhz, .o_bit_time_clamped);
    host_model u_host (.i_ref_clk, .i_rdata(o_cmd_rdata), .i_rvalid(o_cmd_rvalid),
        .o_valid(i_cmd_valid), .o_write(i_cmd_write), .o_addr(i_cmd_addr), .o_wdata(i_cmd_wdata));
    always #25 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cycles++;
        // Whole run needs well under a thousand cycles
        if (cycles == 3000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #2;
    endtask : step
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_host.cmd(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_host.cmd(1'b0, a, 8'h00, q);
        chk("rdata", q, e);
    endtask : rd
    task automatic t_reset_values();
        chk("tc", o_time_constant, TC_16);
        chk("mhz", o_recovery_clock_mhz, MHZ_80);
        rd(ADDR_RECOVERY_ONE, 8'h04);
        rd(ADDR_RECOVERY_TWO, 8'h00);
        rd(7'h40, 8'h00);
    endtask : t_reset_values
    task automatic t_trim_lock();
        wr(ADDR_OSC_FINE_TRIM, 8'hFF);
        rd(ADDR_OSC_FINE_TRIM, 8'h00);
        i_trim_unlock = TRIM_UNLOCKED;
        wr(ADDR_OSC_FINE_TRIM, 8'hA5);
        wr(ADDR_WAKE_OPTIONS, 8'hFF);
        rd(ADDR_WAKE_OPTIONS, 8'h9F);
        chk("tune", o_oscillator_tune_code, 16'h1FA5);
        u_host.wake_select(1'b1, 5'h1F);
        chk("wake", o_wake_receiver_choice, 1'b1);
        i_trim_unlock = 2'h2;
        wr(ADDR_WAKE_OPTIONS, 8'h00);
        chk("wake", o_wake_receiver_choice, 1'b1);
        chk("tune", o_oscillator_tune_code, 16'h1FA5);
        wr(ADDR_CAL_HIGH, 8'h00);
        rd(ADDR_CAL_HIGH, 8'h5A);
        rd(ADDR_CAL_LOW, 8'hC3);
    endtask : t_trim_lock
    task automatic t_recovery();
        logic [3:0] gap[6] = '{4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA};
        logic [5:0] tcx[6] = '{TC_32, TC_32, TC_16, TC_16, TC_8, TC_8};
        wr(ADDR_RECOVERY_ONE, 8'hFF);
        rd(ADDR_RECOVERY_ONE, 8'h0D);
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_RECOVERY_ONE, {4'h0, k[1:0], 2'h0});
            step(1);
            chk("tc", o_time_constant, TC_8 << k);
        end
        chk("on", o_recovery_on, 1'b0);
        wr(ADDR_RECOVERY_ONE, 8'h0C);
        for (int k = 0; k < 6; k++) begin
            i_edge_gap_bits = gap[k];
            step(2);
            chk("tc", o_time_constant, tcx[k]);
        end
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_RECOVERY_TWO, {6'h00, k[1:0]});
            step(1);
            chk("mhz", o_recovery_clock_mhz, MHZ_80 >> k);
        end
        wr(ADDR_RECOVERY_TWO, 8'hFE);
        rd(ADDR_RECOVERY_TWO, 8'h02);
    endtask : t_recovery
    task automatic t_clamp();
        logic [7:0] bt[3] = '{8'hB0, 8'h90, 8'hA8};
        logic [7:0] ex[3] = '{8'hA8, 8'h98, 8'hA8};
        for (int k = 0; k < 3; k++) begin
            i_bit_time = bt[k];
            step(2);
            chk("clamped", o_bit_time_clamped, ex[k]);
        end
    endtask : t_clamp
    task automatic t_soft_reset();
        i_soft_reset = 1'b1;
        step(1);
        i_soft_reset = 1'b0;
        chk("clk", o_recovery_clock_choice, CLK_RESET);
        rd(ADDR_RECOVERY_ONE, 8'h04);
        rd(ADDR_WAKE_OPTIONS, 8'h00);
    endtask : t_soft_reset
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    initial begin
        step(4);
        i_rst_n = 1'b1;
        step(1);
        t_reset_values();
        t_trim_lock();
        t_recovery();
        t_clamp();
        t_soft_reset();
        give_verdict();
    end
endmodule : testbench
bind swk_osc_trim_cdr_regs swk_regs_monitor u_mon (.i_ref_clk, .i_rst_n, .i_soft_reset,
    .i_cmd_valid, .i_cmd_write, .i_cmd_addr, .i_cmd_wdata, .i_trim_unlock, .i_edge_gap_bits,
    .i_bit_time, .i_recovery_upper_limit, .i_recovery_lower_limit, .o_oscillator_tune_code,
    .o_wake_receiver_choice, .o_recovery_on, .o_recovery_filter_constant, .o_time_constant,
    .o_recovery_clock_choice, .o_recovery_clock_mhz, .o_bit_time_clamped);
